//--- rtl/pwc_defines.svh
// register indices, field positions, reset values and write masks of the pwm clock block
`ifndef PWC_DEFINES_SVH
`define PWC_DEFINES_SVH
// register indices; the byte address is four times the index
`define PWC_IDX_CTL 7'h60
`define PWC_IDX_PRESC 7'h61
`define PWC_IDX_SCLA 7'h62
`define PWC_IDX_SCLB 7'h63
// channel_control field positions (two bits each, channel 0 lowest)
`define PWC_CTL_ON_LSB 0
`define PWC_CTL_POL_LSB 2
`define PWC_CTL_SEL_LSB 4
`define PWC_CTL_CAE_LSB 6
// prescale_select field positions
`define PWC_PRE_A_LSB 0
`define PWC_PRE_B_LSB 4
// writable bits of prescale_select; bits 7 and 3 read as zero
`define PWC_PRE_WMASK 8'h77
// reset values
`define PWC_RST_CTL 8'h00
`define PWC_RST_PRESC 8'h00
`define PWC_RST_SCL 8'h00
`endif

//--- rtl/pwc_pkg.sv
// types shared by the pwm clock select and scaler block
`default_nettype none
package pwc_pkg;
  // whole state of the block, registered as one word
  typedef struct packed {
    logic [7:0] ctl;     // channel_control
    logic [7:0] presc;   // prescale_select
    logic [7:0] scla;    // scale_a_value
    logic [7:0] sclb;    // scale_b_value
    logic [6:0] pcnt;    // free prescale counter
    logic [7:0] scnt_a;  // scale a down counter, zero means 256
    logic [7:0] scnt_b;  // scale b down counter, zero means 256
    logic tog_a;         // half period toggle for clock sa
    logic tog_b;         // half period toggle for clock sb
    logic [1:0] phase;   // per channel: duty count already reached
    logic [1:0] pwm;     // per channel output level
    logic [1:0] tick;    // per channel selected clock tick
    logic [31:0] rdata;  // read data captured in the setup phase
  } pwc_state_s;
endpackage : pwc_pkg
`default_nettype wire

//--- rtl/pwc_clock_scaler.sv
// pwm clock select, prescaler, scalers, channel control and apb register slave
//
// Function
// - polarity one: start high, low at duty
// - polarity zero: start low, high at duty
// - polarity writes apply immediately, any time
// - each channel selects between two clocks
// - clock select bits writable any time
// - alignment bit one centre, zero left
// - clock a is interface clock over 2^code
// - clock b is interface clock over 2^code
// - prescale register: b bits 6-4, a 2-0
// - prescale codes writable any time
// - clock sa is clock a over 2*scale
// - clock sb is clock b over 2*scale
// - scale a zero counts as 256
// - scale b zero counts as 256
// - scale write reloads its counter at once
// - channel 0 a/sa, channel 1 b/sb
// - both channels off stops the prescaler
`timescale 1ns/1ps
`default_nettype none
`include "pwc_defines.svh"

module pwc_clock_scaler #(
  parameter int ADDR_W = 12  // apb address width
) (
  input wire logic ref_clk_i,               // 10 mhz interface clock
  input wire logic nrst_i,                  // synchronous reset, active low
  input wire logic psel_i,                  // apb select
  input wire logic penable_i,               // apb access phase
  input wire logic pwrite_i,                // apb direction, high for write
  input wire logic [ADDR_W-1:0] paddr_i,    // apb byte address
  input wire logic [31:0] pwdata_i,         // apb write data
  output logic [31:0] prdata_o,             // apb read data
  output logic pready_o,                    // apb ready, never waits
  output logic pslverr_o,                   // apb error on unmapped address
  input wire logic [1:0] period_start_i,    // counter begins a new cycle
  input wire logic [1:0] duty_match_i,      // counter reached duty count
  output logic [1:0] chan_tick_o,           // selected channel clock tick
  output logic [1:0] channel_on_o,          // channel enables
  output logic [1:0] start_level_select_o,  // channel polarities
  output logic [1:0] center_align_select_o, // channel alignment modes
  output logic [1:0] pwm_o                  // channel waveform outputs
);

  // register byte addresses from their indices
  localparam logic [ADDR_W-1:0] ADDR_CTL = ADDR_W'({`PWC_IDX_CTL, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_PRESC = ADDR_W'({`PWC_IDX_PRESC, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_SCLA = ADDR_W'({`PWC_IDX_SCLA, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_SCLB = ADDR_W'({`PWC_IDX_SCLB, 2'b00});

  pwc_pkg::pwc_state_s s_q;  // current state
  pwc_pkg::pwc_state_s s_d;  // next state

  logic setup;          // apb setup phase
  logic access;         // apb access phase, always completes
  logic wr;             // write taking effect this edge
  logic mapped;         // address hits a register
  logic run;            // at least one channel enabled
  logic [1:0] on;       // enables
  logic [1:0] sel;      // clock selects
  logic [6:0] mask_a;   // prescale mask for clock a
  logic [6:0] mask_b;   // prescale mask for clock b
  logic tick_a;         // clock a tick
  logic tick_b;         // clock b tick
  logic tick_sa;        // clock sa tick
  logic tick_sb;        // clock sb tick
  logic [7:0] rd_mux;   // read data for the current address

  // bus phase decode
  assign setup = psel_i && !penable_i;
  assign access = psel_i && penable_i;
  assign wr = access && pwrite_i;
  assign mapped = (paddr_i == ADDR_CTL) || (paddr_i == ADDR_PRESC)
               || (paddr_i == ADDR_SCLA) || (paddr_i == ADDR_SCLB);

  // control fields
  assign on = s_q.ctl[`PWC_CTL_ON_LSB +: 2];
  assign sel = s_q.ctl[`PWC_CTL_SEL_LSB +: 2];
  assign run = |on;

  // prescaled ticks: clock x ticks when the low code bits of the counter are all ones
  assign mask_a = 7'((8'h01 << s_q.presc[`PWC_PRE_A_LSB +: 3]) - 8'h01);
  assign mask_b = 7'((8'h01 << s_q.presc[`PWC_PRE_B_LSB +: 3]) - 8'h01);
  assign tick_a = run && ((s_q.pcnt & mask_a) == mask_a);
  assign tick_b = run && ((s_q.pcnt & mask_b) == mask_b);

  // scaled ticks: every second expiry of the scale counter
  assign tick_sa = tick_a && (s_q.scnt_a == 8'h01) && s_q.tog_a;
  assign tick_sb = tick_b && (s_q.scnt_b == 8'h01) && s_q.tog_b;

  // read data selection
  always_comb begin
    case (paddr_i)
      ADDR_CTL: begin
        rd_mux = s_q.ctl;
      end
      ADDR_PRESC: begin
        rd_mux = s_q.presc & `PWC_PRE_WMASK;
      end
      ADDR_SCLA: begin
        rd_mux = s_q.scla;
      end
      ADDR_SCLB: begin
        rd_mux = s_q.sclb;
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  // next state
  always_comb begin
    s_d = s_q;
    // read data captured in setup so it comes from a flop in access
    if (setup) begin
      s_d.rdata = {24'h000000, rd_mux};
    end
    // prescale counter runs only while some channel is enabled
    if (run) begin
      s_d.pcnt = s_q.pcnt + 7'h01;
    end else begin
      s_d.pcnt = 7'h00;
    end
    // scaler a: zero wraps to 255 so it counts 256 ticks
    if (tick_a) begin
      if (s_q.scnt_a == 8'h01) begin
        s_d.scnt_a = s_q.scla;
        s_d.tog_a = !s_q.tog_a;
      end else begin
        s_d.scnt_a = s_q.scnt_a - 8'h01;
      end
    end
    // scaler b, same scheme
    if (tick_b) begin
      if (s_q.scnt_b == 8'h01) begin
        s_d.scnt_b = s_q.sclb;
        s_d.tog_b = !s_q.tog_b;
      end else begin
        s_d.scnt_b = s_q.scnt_b - 8'h01;
      end
    end
    // register writes, accepted at any time
    if (wr) begin
      case (paddr_i)
        ADDR_CTL: begin
          s_d.ctl = pwdata_i[7:0];
        end
        ADDR_PRESC: begin
          s_d.presc = pwdata_i[7:0] & `PWC_PRE_WMASK;
        end
        ADDR_SCLA: begin
          s_d.scla = pwdata_i[7:0];
          s_d.scnt_a = pwdata_i[7:0];
        end
        ADDR_SCLB: begin
          s_d.sclb = pwdata_i[7:0];
          s_d.scnt_b = pwdata_i[7:0];
        end
        default: begin
          s_d.ctl = s_q.ctl;
        end
      endcase
    end
    // channel clock: prescaled or scaled source
    s_d.tick[0] = sel[0] ? tick_sa : tick_a;
    s_d.tick[1] = sel[1] ? tick_sb : tick_b;
    // waveform phase and output level per channel
    for (int i = 0; i < 2; i++) begin
      if (!s_d.ctl[`PWC_CTL_ON_LSB + i]) begin
        s_d.phase[i] = 1'b0;
      end else if (duty_match_i[i]) begin
        s_d.phase[i] = 1'b1;
      end else if (period_start_i[i]) begin
        s_d.phase[i] = 1'b0;
      end
      // new polarity takes effect at once, even mid pulse
      s_d.pwm[i] = s_d.ctl[`PWC_CTL_POL_LSB + i] ^ s_d.phase[i];
    end
  end

  // state register with synchronous reset
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      s_q <= '0;
      s_q.ctl <= `PWC_RST_CTL;
      s_q.presc <= `PWC_RST_PRESC;
      s_q.scla <= `PWC_RST_SCL;
      s_q.sclb <= `PWC_RST_SCL;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs
  assign prdata_o = s_q.rdata;
  assign pready_o = 1'b1;
  assign pslverr_o = access && !mapped;
  assign chan_tick_o = s_q.tick;
  assign channel_on_o = on;
  assign start_level_select_o = s_q.ctl[`PWC_CTL_POL_LSB +: 2];
  assign center_align_select_o = s_q.ctl[`PWC_CTL_CAE_LSB +: 2];
  assign pwm_o = s_q.pwm;

  // checks
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);

  // polarity one: high after start of a cycle
  property p_start_high;
    (on[0] && s_q.ctl[`PWC_CTL_POL_LSB] && period_start_i[0] && !duty_match_i[0] && !wr) |=> pwm_o[0];
  endproperty
  a_start_high: assert property (p_start_high) else $error("polarity one did not start high");

  // polarity zero: high after duty reached
  property p_duty_high;
    (on[1] && !s_q.ctl[`PWC_CTL_POL_LSB + 1] && duty_match_i[1] && !wr) |=> pwm_o[1];
  endproperty
  a_duty_high: assert property (p_duty_high) else $error("polarity zero did not go high at duty");

  // polarity write sets channel 0 output from the new polarity next cycle when the phase holds
  property p_pol_now;
    (wr && paddr_i == ADDR_CTL && !duty_match_i[0] && !period_start_i[0])
      |=> (pwm_o[0] == ($past(pwdata_i[`PWC_CTL_POL_LSB]) ^ s_q.phase[0]));
  endproperty
  a_pol_now: assert property (p_pol_now) else $error("polarity change not applied at once");

  // code zero with channel 0 on and clock a chosen ticks every cycle
  property p_div1;
    (on[0] && !sel[0] && s_q.presc[2:0] == 3'h0 && !wr) |=> chan_tick_o[0];
  endproperty
  a_div1: assert property (p_div1) else $error("clock a code zero did not tick each cycle");

  // divide by two gives no two ticks in a row
  property p_div2;
    (chan_tick_o[1] && !sel[1] && $past(s_q.presc[6:4]) == 3'h1 && s_q.presc[6:4] == 3'h1) |=> !chan_tick_o[1];
  endproperty
  a_div2: assert property (p_div2) else $error("clock b divide by two ticked twice");

  // reserved prescale bits read as zero
  property p_presc_rsv;
    (setup && paddr_i == ADDR_PRESC) |=> (prdata_o[7] == 1'b0 && prdata_o[3] == 1'b0);
  endproperty
  a_presc_rsv: assert property (p_presc_rsv) else $error("reserved prescale bits not zero");

  // scale write reloads the counter
  property p_reload;
    (wr && paddr_i == ADDR_SCLA) |=> (s_q.scnt_a == $past(pwdata_i[7:0]));
  endproperty
  a_reload: assert property (p_reload) else $error("scale a write did not reload counter");

  // scaled selection only ticks on the second expiry
  property p_sel_sa;
    (on[0] && sel[0] && !tick_sa) |=> !chan_tick_o[0];
  endproperty
  a_sel_sa: assert property (p_sel_sa) else $error("scaled channel ticked without clock sa");

  // all channels off: no prescaled ticks now and the counter parked at zero next
  property p_stop;
    (!run) |-> (!tick_a && !tick_b) ##1 (s_q.pcnt == 7'h00);
  endproperty
  a_stop: assert property (p_stop) else $error("prescaler ran with both channels off");

  // polarity zero: low after start of a cycle
  property p_start_low;
    (on[0] && !s_q.ctl[`PWC_CTL_POL_LSB] && period_start_i[0] && !duty_match_i[0] && !wr) |=> !pwm_o[0];
  endproperty
  a_start_low: assert property (p_start_low) else $error("polarity zero did not start low");

  // polarity one: low after duty reached
  property p_duty_low;
    (on[1] && s_q.ctl[`PWC_CTL_POL_LSB + 1] && duty_match_i[1] && !wr) |=> !pwm_o[1];
  endproperty
  a_duty_low: assert property (p_duty_low) else $error("polarity one did not go low at duty");

  // a disabled channel rests at its start level
  property p_off_level;
    (!on[0] && !wr) |=> (pwm_o[0] == start_level_select_o[0]);
  endproperty
  a_off_level: assert property (p_off_level) else $error("disabled channel not at start level");

  // channel 1 on clock b follows the prescaled tick
  property p_sel_b;
    (!sel[1]) |=> (chan_tick_o[1] == $past(tick_b));
  endproperty
  a_sel_b: assert property (p_sel_b) else $error("channel 1 did not follow clock b");

  // channel 1 on clock sb ticks only with clock sb
  property p_sel_sb;
    (sel[1] && !tick_sb) |=> !chan_tick_o[1];
  endproperty
  a_sel_sb: assert property (p_sel_sb) else $error("scaled channel ticked without clock sb");

  // scale b write reloads its counter
  property p_reload_b;
    (wr && paddr_i == ADDR_SCLB) |=> (s_q.scnt_b == $past(pwdata_i[7:0]));
  endproperty
  a_reload_b: assert property (p_reload_b) else $error("scale b write did not reload counter");

  // scale a counter passes through zero so zero counts as 256
  property p_wrap_a;
    (tick_a && s_q.scnt_a == 8'h00 && !wr) |=> (s_q.scnt_a == 8'hff);
  endproperty
  a_wrap_a: assert property (p_wrap_a) else $error("scale a counter did not wrap from zero");

  // scale b counter passes through zero so zero counts as 256
  property p_wrap_b;
    (tick_b && s_q.scnt_b == 8'h00 && !wr) |=> (s_q.scnt_b == 8'hff);
  endproperty
  a_wrap_b: assert property (p_wrap_b) else $error("scale b counter did not wrap from zero");

  // expiry reloads the scale value and flips the half period toggle
  property p_toggle_a;
    (tick_a && s_q.scnt_a == 8'h01 && !wr) |=> (s_q.tog_a != $past(s_q.tog_a) && s_q.scnt_a == $past(s_q.scla));
  endproperty
  a_toggle_a: assert property (p_toggle_a) else $error("scale a expiry did not reload and toggle");

  // prescale write keeps only the two code fields
  property p_presc_wr;
    (wr && paddr_i == ADDR_PRESC) |=> (s_q.presc == ($past(pwdata_i[7:0]) & `PWC_PRE_WMASK));
  endproperty
  a_presc_wr: assert property (p_presc_wr) else $error("prescale write not taken");

  // scale a write stores the new value
  property p_scla_wr;
    (wr && paddr_i == ADDR_SCLA) |=> (s_q.scla == $past(pwdata_i[7:0]));
  endproperty
  a_scla_wr: assert property (p_scla_wr) else $error("scale a write not stored");

  // control writes are taken at any time
  property p_ctl_wr;
    (wr && paddr_i == ADDR_CTL) |=> (s_q.ctl == $past(pwdata_i[7:0]));
  endproperty
  a_ctl_wr: assert property (p_ctl_wr) else $error("control write not taken");

  // main scenarios
  c_zero_scale: cover property (tick_a && s_q.scnt_a == 8'h00);
  c_sa_tick: cover property (on[0] && sel[0] ##1 chan_tick_o[0]);
  c_scale_write: cover property (wr && paddr_i == ADDR_SCLB);
  c_pol_flip: cover property (on[1] && $changed(start_level_select_o[1]));
  c_unmapped: cover property (pslverr_o);

endmodule : pwc_clock_scaler

`default_nettype wire

//--- testbench/pwc_load_model.sv
// behavioural model of the external channel counter feeding the waveform inputs
`timescale 1ns/1ps
`default_nettype none
module pwc_load_model #(
  parameter int PER = 4,  // channel ticks per period
  parameter int DUTY = 2  // tick count of the duty match
) (
  input wire logic ref_clk_i,     // interface clock
  input wire logic [1:0] tick_i,  // selected channel clock ticks
  output logic [1:0] start_o,     // a new period begins
  output logic [1:0] match_o      // duty count reached
);
  int cnt [2] = '{0, 0};  // per channel tick count
  // count ticks; flags stand for one cycle only
  always @(posedge ref_clk_i) begin
    for (int c = 0; c < 2; c++) begin
      start_o[c] <= tick_i[c] && cnt[c] == 0;
      match_o[c] <= tick_i[c] && cnt[c] == DUTY;
      if (tick_i[c]) cnt[c] <= (cnt[c] + 1) % PER;
    end
  end
endmodule : pwc_load_model
`default_nettype wire

//--- testbench/pwc_clock_scaler_tb.sv
// self-checking testbench of the pwm clock select and scaler block
`timescale 1ns/1ps
`default_nettype none
module pwc_clock_scaler_tb;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;  // bus read data and last taken value
  logic pready, pslverr, err;
  logic [1:0] pst, dmt, tick, on, pol, cae, pwm;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int g;  // cycles counted by the gap task
  always #50 ref_clk_i = ~ref_clk_i;
  pwc_clock_scaler dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .period_start_i(pst), .duty_match_i(dmt), .chan_tick_o(tick),
    .channel_on_o(on), .start_level_select_o(pol), .center_align_select_o(cae), .pwm_o(pwm));
  pwc_load_model load (.ref_clk_i(ref_clk_i), .tick_i(tick), .start_o(pst), .match_o(dmt));
  // compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer; read data and error taken at the ready edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    do @(posedge ref_clk_i); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // wait for n channel ticks; g ends as cycles to the last one
  task gap(input int ch, input int n);
    for (int k = 0; k < n; k++) begin
      g = 0;
      do begin
        @(negedge ref_clk_i);
        g++;
      end while (tick[ch] !== 1'b1 && g < 1200);
    end
  endtask : gap
  // start level after period start, inverse after duty match
  task polchk(input int ch, input logic p);
    do @(negedge ref_clk_i); while (pst[ch] !== 1'b1);
    @(negedge ref_clk_i);
    chk(32'(pwm[ch]), 32'(p));
    do @(negedge ref_clk_i); while (dmt[ch] !== 1'b1);
    @(negedge ref_clk_i);
    chk(32'(pwm[ch]), 32'(!p));
  endtask : polchk
  // expected tick spacing in interface clock cycles
  function automatic logic [31:0] exp_gap(int code, int sel, int scl);
    return (32'h1 << code) * (sel ? 2 * (scl == 0 ? 256 : scl) : 1);
  endfunction : exp_gap
  // counts, verdict and end of run
  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up
  // hang guard
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      wrap_up();
    end
  end
  initial begin
    int ca, cb, s;
    void'($urandom(77));
    repeat (3) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 12'h180 + 12'(4 * i), 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b0, 12'h190, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    apb(1'b1, 12'h184, 32'hff);
    apb(1'b0, 12'h184, 32'h0);
    chk(rd, 32'h77);
    $display("test registers done");
    apb(1'b1, 12'h180, 32'h03);
    repeat (4) begin
      ca = $urandom_range(3);
      cb = $urandom_range(3);
      apb(1'b1, 12'h184, 32'((cb << 4) | ca));
      gap(0, 3);
      chk(32'(g), exp_gap(ca, 0, 0));
      gap(1, 3);
      chk(32'(g), exp_gap(cb, 0, 0));
    end
    $display("test prescale done");
    apb(1'b1, 12'h180, 32'h33);
    repeat (3) begin
      s = $urandom_range(1, 4);
      apb(1'b1, 12'h188, 32'(s));
      apb(1'b1, 12'h18c, 32'(s + 1));
      gap(0, 3);
      chk(32'(g), exp_gap(ca, 1, s));
      gap(1, 3);
      chk(32'(g), exp_gap(cb, 1, s + 1));
    end
    apb(1'b1, 12'h184, 32'h0);
    apb(1'b1, 12'h188, 32'h0);
    apb(1'b1, 12'h18c, 32'h0);
    gap(0, 3);
    chk(32'(g), 32'h200);
    gap(1, 3);
    chk(32'(g), 32'h200);
    apb(1'b1, 12'h188, 32'hff);
    gap(0, 2);
    apb(1'b1, 12'h188, 32'h2);
    gap(0, 1);
    chk(32'(g <= 10), 32'h1);
    $display("test scalers done");
    apb(1'b1, 12'h180, 32'h00);
    repeat (2) @(negedge ref_clk_i);
    gap(0, 1);
    chk(32'(g), 32'(1200));
    for (int p = 0; p < 4; p++) begin
      apb(1'b1, 12'h180, 32'h0);
      apb(1'b1, 12'h180, 32'(p << 6));
      @(negedge ref_clk_i);
      chk(32'(cae), 32'(p));
      apb(1'b1, 12'h180, 32'((p << 6) | (p << 2) | 3));
      @(negedge ref_clk_i);
      chk(32'({on, pol}), 32'((3 << 2) | p));
      polchk(0, p[0]);
      polchk(1, p[1]);
    end
    $display("test polarity done");
    wrap_up();
  end
endmodule : pwc_clock_scaler_tb
`default_nettype wire
